// *** verilog/abrp_pkg.sv ***
// Shared constants, types and helpers for the block RAM read port controller.
package abrp_pkg;

    // ------------------------------------------------------------------
    // Configuration defaults
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ID_W = 4;
    localparam int ADDR_W = 32;
    localparam int ECC = 1;
    localparam int SINGLE_PORT = 0;
    localparam logic [31:0] WIN_BASE = 32'h0000_0000;
    localparam logic [31:0] WIN_HIGH = 32'h0000_0fff;
    localparam int CHK_W = 8;
    localparam int APB_AW = 12;
    localparam int ERRCNT_W = 8;

    // ------------------------------------------------------------------
    // Control register map and fields
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_ONOFF = 12'h008;
    localparam logic [11:0] OFS_ERRCNT = 12'h010;
    localparam int STATUS_ERR_BIT = 0;
    localparam int ONOFF_BIT = 0;
    localparam logic ONOFF_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------------
    // Sequencer states, Gray coded along the read path except ST_RD_BEAT to ST_RD_REQ
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RD_REQ = 3'h1,
        ST_RD_WAIT = 3'h3,
        ST_RD_BEAT = 3'h2,
        ST_RMW_RD = 3'h4,
        ST_RMW_WAIT = 3'h5,
        ST_WR_DO = 3'h7
    } abrp_state_t;

    // Check byte is the XOR of all data bytes; detects, does not correct.
    function automatic logic [7:0] abrp_check(input logic [1023:0] d,
                                              input int nb);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 128; i++) begin
            if (i < nb) begin
                c = c ^ d[i*8 +: 8];
            end
        end
        return c;
    endfunction

endpackage

// *** verilog/abrp_rd_capture.sv ***
// Read data capture stage with check byte test and registered response.
module abrp_rd_capture import abrp_pkg::*; #(
    parameter int DW = DATA_W,
    parameter int MW = DATA_W + CHK_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic capture,
    input wire logic check_on,
    input wire logic [MW-1:0] raw,
    output logic [DW-1:0] data_q,
    output logic [1:0] resp_q
);

    logic [7:0] stored_chk;
    logic [7:0] calc_chk;

    // Stored byte sits above the data; reads as zero when no check bits.
    assign stored_chk = 8'(raw >> DW);
    assign calc_chk = abrp_check(1024'(raw[DW-1:0]), DW / 8);

    // Capture on the cycle the memory output is valid, hold until next.
    always_ff @(posedge clk) begin
        if (rst) begin
            data_q <= '0;
            resp_q <= RESP_OKAY;
        end else if (capture) begin
            data_q <= raw[DW-1:0];
            // Mismatch is the only error source, so SLVERR or OKAY only.
            if (check_on && (stored_chk != calc_chk)) begin
                resp_q <= RESP_SLVERR;
            end else begin
                resp_q <= RESP_OKAY;
            end
        end
    end

endmodule // abrp_rd_capture

// *** verilog/abrp_ctrl.sv ***
// Block RAM controller: read address/data channels, write request, APB.
module abrp_ctrl import abrp_pkg::*; #(
    parameter int DW = DATA_W,
    parameter int IW = ID_W,
    parameter int AW = ADDR_W,
    parameter int ECC_EN = ECC,
    parameter int SINGLE = SINGLE_PORT,
    parameter logic [31:0] window_base_address = WIN_BASE,
    parameter logic [31:0] window_high_address = WIN_HIGH,
    parameter int MW = DW + CHK_W * ECC_EN,
    parameter int SW = DW / 8,
    parameter int WEW = SW + ECC_EN,
    parameter int BAW = $clog2(window_high_address - window_base_address
                               + 32'h1) - $clog2(SW)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [IW-1:0] s_axi_arid,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic [7:0] s_axi_arlen,
    input wire logic [3:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [IW-1:0] s_axi_rid,
    output logic [DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rlast,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [SW-1:0] wr_strb,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic bram_rst_a,
    output logic bram_clk_a,
    output logic bram_en_a,
    output logic [WEW-1:0] bram_we_a,
    output logic [BAW-1:0] bram_addr_a,
    output logic [MW-1:0] bram_wrdata_a,
    input wire logic [MW-1:0] bram_rddata_a,
    output logic bram_rst_b,
    output logic bram_clk_b,
    output logic bram_en_b,
    output logic [WEW-1:0] bram_we_b,
    output logic [BAW-1:0] bram_addr_b,
    output logic [MW-1:0] bram_wrdata_b,
    input wire logic [MW-1:0] bram_rddata_b
);

    localparam int BYTE_SH = $clog2(SW);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    abrp_state_t state, next_state;
    logic grant_rd, next_grant;
    logic [7:0] burst_left, next_left;
    logic [BAW-1:0] rd_addr, next_rd_addr;
    logic [BAW-1:0] waddr, next_waddr;
    logic [DW-1:0] wdata, next_wdata;
    logic [SW-1:0] wstrb, next_wstrb;
    logic ar_take, wr_take, beat_done;
    logic ecc_on, err_flag, err_event;
    logic [ERRCNT_W-1:0] err_cnt;
    logic apb_wr, apb_setup;
    logic [MW-1:0] rd_raw;

    // Only ever one requester is offered ready, so a cycle in which both
    // are valid cannot complete two handshakes at once.
    assign ar_take = (state == ST_IDLE) && s_axi_arready && s_axi_arvalid;
    assign wr_take = (state == ST_IDLE) && wr_ready && wr_valid;
    assign beat_done = s_axi_rvalid && s_axi_rready;
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready && pwrite;

    // ------------------------------------------------------------------
    // Register decode helpers
    // ------------------------------------------------------------------
    function automatic logic reg_mapped(input logic [APB_AW-1:0] a);
        return (a == OFS_STATUS) || (a == OFS_ONOFF) || (a == OFS_ERRCNT);
    endfunction

    function automatic logic [31:0] reg_value(input logic [APB_AW-1:0] a,
                                              input logic e,
                                              input logic on,
                                              input logic [7:0] cnt);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == OFS_STATUS) begin
            v[STATUS_ERR_BIT] = e;
        end else if (a == OFS_ONOFF) begin
            v[ONOFF_BIT] = on;
        end else if (a == OFS_ERRCNT) begin
            v[7:0] = cnt;
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // One request at a time; reads and writes share the sequencer so a
    // single-port memory never sees two accesses in one cycle.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (ar_take) begin
                    next_state = ST_RD_REQ;
                end else if (wr_take) begin
                    if (ECC_EN != 0 && !(&wr_strb)) begin
                        next_state = ST_RMW_RD;
                    end else begin
                        next_state = ST_WR_DO;
                    end
                end
            end
            ST_RD_REQ: next_state = ST_RD_WAIT;
            ST_RD_WAIT: next_state = ST_RD_BEAT;
            ST_RD_BEAT: begin
                if (beat_done) begin
                    next_state = (burst_left == 8'h00) ? ST_IDLE : ST_RD_REQ;
                end
            end
            ST_RMW_RD: next_state = ST_RMW_WAIT;
            ST_RMW_WAIT: next_state = ST_WR_DO;
            ST_WR_DO: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Next values for the address, burst and write buffer
    // ------------------------------------------------------------------
    // Burst addresses step one word per beat; only the start is given.
    always_comb begin
        next_grant = (state == ST_IDLE) ? !grant_rd : grant_rd;
        next_left = burst_left;
        next_rd_addr = rd_addr;
        if (ar_take) begin
            next_left = s_axi_arlen;
            next_rd_addr = BAW'((s_axi_araddr - AW'(window_base_address))
                                >> BYTE_SH);
        end else if (beat_done && burst_left != 8'h00) begin
            next_left = burst_left - 8'h01;
            next_rd_addr = rd_addr + BAW'(1);
        end
    end

    // Partial write with checking merges new bytes over the old word.
    always_comb begin
        next_waddr = waddr;
        next_wstrb = wstrb;
        next_wdata = wdata;
        if (wr_take) begin
            next_waddr = BAW'((wr_addr - AW'(window_base_address)) >> BYTE_SH);
            next_wstrb = wr_strb;
            next_wdata = wr_data;
        end else if (state == ST_RMW_WAIT) begin
            for (int i = 0; i < SW; i++) begin
                next_wdata[i*8 +: 8] = wstrb[i] ? wdata[i*8 +: 8]
                                                : bram_rddata_a[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            grant_rd <= 1'b1;
            burst_left <= 8'h00;
            rd_addr <= '0;
            waddr <= '0;
            wstrb <= '0;
            wdata <= '0;
        end else begin
            grant_rd <= next_grant;
            burst_left <= next_left;
            rd_addr <= next_rd_addr;
            waddr <= next_waddr;
            wstrb <= next_wstrb;
            wdata <= next_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Request handshakes
    // ------------------------------------------------------------------
    // Readies are registered: high only in idle, alternating between the
    // two requesters so neither can starve the other.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            wr_ready <= 1'b0;
        end else begin
            s_axi_arready <= (next_state == ST_IDLE) && next_grant;
            wr_ready <= (next_state == ST_IDLE) && !next_grant;
        end
    end

    // The identifier is latched with the request and held for the burst;
    // the protection attribute is never looked at.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rid <= '0;
        end else if (ar_take) begin
            s_axi_rid <= s_axi_arid;
        end
    end

    // ------------------------------------------------------------------
    // Read data channel
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rlast <= 1'b0;
        end else begin
            s_axi_rvalid <= (next_state == ST_RD_BEAT);
            s_axi_rlast <= (next_state == ST_RD_BEAT)
                           && (next_left == 8'h00);
        end
    end

    // Read data come from port A in single-port mode, else port B.
    assign rd_raw = (SINGLE != 0) ? bram_rddata_a : bram_rddata_b;

    abrp_rd_capture #(
        .DW(DW),
        .MW(MW)
    ) u_capture (
        .clk(clk),
        .rst(rst),
        .capture(state == ST_RD_WAIT),
        .check_on((ECC_EN != 0) && ecc_on),
        .raw(rd_raw),
        .data_q(s_axi_rdata),
        .resp_q(s_axi_rresp)
    );

    // ------------------------------------------------------------------
    // Memory ports
    // ------------------------------------------------------------------
    // Clocks are forwarded directly; a flop here would add a phase shift.
    assign bram_clk_a = clk;
    assign bram_clk_b = clk;
    assign bram_we_b = '0;
    assign bram_wrdata_b = '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            bram_rst_a <= 1'b1;
            bram_rst_b <= 1'b1;
        end else begin
            bram_rst_a <= 1'b0;
            bram_rst_b <= 1'b0;
        end
    end

    // Port A: writes, read-modify-write fetches and single-port reads.
    always_ff @(posedge clk) begin
        if (rst) begin
            bram_en_a <= 1'b0;
            bram_we_a <= '0;
            bram_addr_a <= '0;
            bram_wrdata_a <= '0;
        end else begin
            bram_en_a <= (next_state == ST_RMW_RD) || (next_state == ST_WR_DO)
                         || (SINGLE != 0 && next_state == ST_RD_REQ);
            if (next_state == ST_RD_REQ) begin
                bram_addr_a <= next_rd_addr;
            end else begin
                bram_addr_a <= next_waddr;
            end
            if (next_state == ST_WR_DO) begin
                // Checked writes are always whole words so the byte stays
                // consistent; the old bytes came in by the fetch.
                bram_we_a <= (ECC_EN != 0) ? {WEW{1'b1}}
                                           : WEW'(next_wstrb);
                bram_wrdata_a <= MW'({abrp_check(1024'(next_wdata), SW),
                                      next_wdata});
            end else begin
                bram_we_a <= '0;
                bram_wrdata_a <= '0;
            end
        end
    end

    // Port B: read-only, active only in dual-port mode.
    always_ff @(posedge clk) begin
        if (rst) begin
            bram_en_b <= 1'b0;
            bram_addr_b <= '0;
        end else begin
            bram_en_b <= (SINGLE == 0) && (next_state == ST_RD_REQ);
            bram_addr_b <= (SINGLE == 0) ? next_rd_addr : '0;
        end
    end

    // ------------------------------------------------------------------
    // Error status and count
    // ------------------------------------------------------------------
    assign err_event = beat_done && (s_axi_rresp == RESP_SLVERR);

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            err_flag <= 1'b0;
        end else if (err_event) begin
            err_flag <= 1'b1;
        end else if (apb_wr && ECC_EN != 0 && paddr == OFS_STATUS
                     && pwdata[STATUS_ERR_BIT]) begin
            err_flag <= 1'b0;
        end
    end

    // Counter saturates rather than wrap; software may preset it.
    always_ff @(posedge clk) begin
        if (rst) begin
            err_cnt <= '0;
        end else if (apb_wr && ECC_EN != 0 && paddr == OFS_ERRCNT) begin
            err_cnt <= pwdata[ERRCNT_W-1:0];
        end else if (err_event && err_cnt != {ERRCNT_W{1'b1}}) begin
            err_cnt <= err_cnt + ERRCNT_W'(1);
        end
    end

    // Checking switch steers the capture stage.
    always_ff @(posedge clk) begin
        if (rst) begin
            ecc_on <= ONOFF_RST;
        end else if (apb_wr && ECC_EN != 0 && paddr == OFS_ONOFF) begin
            ecc_on <= pwdata[ONOFF_BIT];
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Answer in the first access cycle. With checking absent the port is
    // inert: reads give zero and every access is refused.
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            if (apb_setup) begin
                pslverr <= (ECC_EN == 0) || !reg_mapped(paddr);
                if (ECC_EN != 0 && !pwrite) begin
                    prdata <= reg_value(paddr, err_flag, ecc_on,
                                        8'(err_cnt));
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule // abrp_ctrl

// *** sim/abrp_bram_model.sv ***
// Behavioural dual-port block RAM seen by the controller's memory ports.
module abrp_bram_model #(
    parameter int AW = 10,
    parameter int MW = 40
) (
    input wire logic clk,
    input wire logic en_a,
    input wire logic [4:0] we_a,
    input wire logic [AW-1:0] addr_a,
    input wire logic [MW-1:0] wd_a,
    output logic [MW-1:0] rd_a,
    input wire logic en_b,
    input wire logic [AW-1:0] addr_b,
    output logic [MW-1:0] rd_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [MW-1:0] mem [1024];
    // Zero fill keeps every stored check byte consistent with its data.
    initial begin
        foreach (mem[i]) mem[i] = '0;
        rd_a = '0;
        rd_b = '0;
    end
    // One cycle read latency; an idle port flips its bus so stale data
    // is never mistaken for a fresh read.
    always @(posedge clk) begin
        if (en_a) begin
            rd_a <= mem[addr_a];
            for (int i = 0; i < 5; i++) begin
                if (we_a[i]) mem[addr_a][i*8 +: 8] <= wd_a[i*8 +: 8];
            end
        end else rd_a <= ~rd_a;
        if (en_b) rd_b <= mem[addr_b];
        else rd_b <= ~rd_b;
    end
endmodule // abrp_bram_model

// *** sim/abrp_monitor.sv ***
// Checker of the block RAM controller, watching its top-level ports.
module abrp_monitor import abrp_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ID_W-1:0] s_axi_arid,
    input wire logic [7:0] s_axi_arlen,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ID_W-1:0] s_axi_rid,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rlast,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic [DATA_W/8-1:0] wr_strb,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic bram_rst_a,
    input wire logic bram_rst_b,
    input wire logic bram_clk_a,
    input wire logic bram_clk_b,
    input wire logic bram_en_a,
    input wire logic [DATA_W/8+ECC-1:0] bram_we_a,
    input wire logic [DATA_W/8+ECC-1:0] bram_we_b,
    input wire logic [DATA_W+CHK_W*ECC-1:0] bram_wrdata_b
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] len_q;
    logic [7:0] beat;
    logic [ID_W-1:0] id_q;
    // Burst length, identifier and beat number of the burst in flight.
    always_ff @(posedge clk) begin
        if (rst) begin
            beat <= 8'h00;
            len_q <= 8'h00;
            id_q <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            beat <= 8'h00;
            len_q <= s_axi_arlen;
            id_q <= s_axi_arid;
        end else if (s_axi_rvalid && s_axi_rready) begin
            beat <= beat + 8'h01;
        end
    end
    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    a_rd_take_latency: assert property (s_axi_arvalid && s_axi_arready
        |=> !s_axi_arready [*2] ##1 s_axi_rvalid) else $error("late rvalid");
    a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rlast))
        else $error("beat dropped");
    a_rresp_legal: assert property (s_axi_rvalid
        |-> s_axi_rresp == RESP_OKAY || s_axi_rresp == RESP_SLVERR)
        else $error("bad rresp");
    a_rid_echo: assert property (s_axi_rvalid |-> s_axi_rid == id_q)
        else $error("rid mismatch");
    a_rlast_final: assert property (s_axi_rvalid
        |-> s_axi_rlast == (beat == len_q)) else $error("rlast wrong");
    a_portb_quiet: assert property (bram_we_b == '0
        && bram_wrdata_b == '0) else $error("port B writes");
    // Forwarded clocks must be high in the high phase of the bus clock.
    a_mem_clock: assert property (@(negedge clk) bram_clk_a
        && bram_clk_b) else $error("memory clock out of phase");
    a_reset_quiet: assert property ($fell(rst) |-> !s_axi_arready
        && !s_axi_rvalid && !s_axi_rlast && s_axi_rdata == '0 && !pready
        && !wr_ready && !bram_en_a && bram_we_a == '0)
        else $error("output live in reset");
    a_mem_reset_out: assert property ($fell(rst) |-> bram_rst_a
        && bram_rst_b ##1 !bram_rst_a && !bram_rst_b)
        else $error("memory reset wrong");
    a_full_write: assert property (wr_valid && wr_ready && &wr_strb
        |=> bram_en_a && &bram_we_a) else $error("full write missed");
    a_rmw_fetch: assert property (wr_valid && wr_ready && !(&wr_strb)
        |=> bram_en_a && bram_we_a == '0 ##2 bram_en_a && &bram_we_a)
        else $error("merge write wrong");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no pready");
    c_burst_end: cover property (s_axi_rvalid && s_axi_rready && s_axi_rlast);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_partial: cover property (wr_valid && wr_ready && !(&wr_strb));
endmodule // abrp_monitor
bind abrp_ctrl abrp_monitor mon_u (.clk, .rst, .s_axi_arid, .s_axi_arlen,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rid, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rlast, .s_axi_rvalid, .s_axi_rready, .wr_valid, .wr_ready,
    .wr_strb, .psel, .penable, .pready, .bram_rst_a, .bram_rst_b,
    .bram_clk_a, .bram_clk_b,
    .bram_en_a, .bram_we_a, .bram_we_b, .bram_wrdata_b);

// *** sim/abrp_ctrl_tb.sv ***
// Self-checking testbench of the block RAM controller.
module abrp_ctrl_tb import abrp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] s_axi_arid, s_axi_rid, s_axi_arprot, wr_strb;
    logic [31:0] s_axi_araddr, wr_addr, s_axi_rdata, wr_data, pwdata, prdata;
    logic [7:0] s_axi_arlen;
    logic [1:0] s_axi_rresp;
    logic s_axi_arvalid, s_axi_arready, s_axi_rlast, s_axi_rvalid;
    logic s_axi_rready, wr_valid, wr_ready, psel, penable, pwrite;
    logic pready, pslverr, bram_rst_a, bram_clk_a, bram_en_a;
    logic bram_rst_b, bram_clk_b, bram_en_b;
    logic [11:0] paddr;
    logic [4:0] bram_we_a, bram_we_b;
    logic [9:0] bram_addr_a, bram_addr_b;
    logic [39:0] bram_wrdata_a, bram_rddata_a, bram_wrdata_b, bram_rddata_b;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int errn = 0;
    int seed = 32'h803b7ff8;
    bit [31:0] ref_m [16];
    bit bad [16];
    bit on = 1'b1;
    logic [31:0] r;
    logic e;
    always #2 clk = ~clk;
    abrp_ctrl dut_u (.*);
    abrp_bram_model mem_u (.clk(clk), .en_a(bram_en_a), .we_a(bram_we_a),
        .addr_a(bram_addr_a), .wd_a(bram_wrdata_a), .rd_a(bram_rddata_a),
        .en_b(bram_en_b), .addr_b(bram_addr_b), .rd_b(bram_rddata_b));
    // A hang ends the run as a failure instead of stalling forever.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [39:0] s, input logic [39:0] x);
        tests_run++;
        if (s !== x) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic apb(input bit w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Word write; the model merges only the strobed bytes.
    task automatic wr(input int w, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        wr_addr <= w * 4;
        wr_data <= d;
        wr_strb <= s;
        wr_valid <= 1'b1;
        do @(posedge clk); while (wr_ready !== 1'b1);
        wr_valid <= 1'b0;
        for (int i = 0; i < 4; i++) if (s[i]) ref_m[w][i*8 +: 8] = d[i*8 +: 8];
    endtask
    task automatic rd(input int w, input int n);
        logic [3:0] id;
        id = $random(seed);
        @(posedge clk);
        s_axi_araddr <= w * 4;
        s_axi_arlen <= n;
        s_axi_arid <= id;
        s_axi_arprot <= $random(seed);
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        for (int b = 0; b <= n; b++) begin
            do begin
                s_axi_rready <= $random(seed);
                @(posedge clk);
            end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
            chk(s_axi_rdata, ref_m[w+b]);
            chk(s_axi_rlast, b == n);
            chk(s_axi_rid, id);
            e = bad[w+b] && on;
            chk(s_axi_rresp, e ? RESP_SLVERR : RESP_OKAY);
            if (e) errn++;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {s_axi_arid, s_axi_araddr, s_axi_arlen, s_axi_arprot} <= '0;
        {s_axi_arvalid, s_axi_rready, wr_valid, wr_addr, wr_data} <= '0;
        {wr_strb, paddr, psel, penable, pwrite, pwdata} <= '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(bram_rst_a, 1'b0);
        apb(1'b0, OFS_ONOFF, 32'h0);
        chk({r, e}, {31'h0, ONOFF_RST, 1'b0});
        for (int i = 0; i < 16; i++) wr(i, $random(seed), 4'hf);
        for (int i = 0; i < 6; i++) begin
            wr(i * 2, $random(seed), 4'h3 << i % 3);
        end
        rd(0, 15);
        rd(5, 0);
        rd(15, 0);
        // A flipped stored bit must come back flagged, and be counted.
        mem_u.mem[3] = mem_u.mem[3] ^ 40'h1;
        ref_m[3] ^= 32'h1;
        bad[3] = 1'b1;
        rd(2, 2);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(r, 32'h1);
        apb(1'b0, OFS_ERRCNT, 32'h0);
        chk(r, errn);
        apb(1'b1, OFS_STATUS, 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, OFS_ONOFF, 32'h0);
        on = 1'b0;
        rd(3, 0);
        apb(1'b0, 12'h0fc, 32'h0);
        chk({r, e}, {32'h0, 1'b1});
        give_verdict();
    end
endmodule // abrp_ctrl_tb
